// ---- src/keypad_monitor_defines.vh ----
// constants for the keypad monitor control block
// assumes a single 50 MHz system clock and a decoded key code input
`ifndef KEYPAD_MONITOR_DEFINES_VH
`define KEYPAD_MONITOR_DEFINES_VH

// key codes: 00-0F hex digits, 10 upward function keys
`define KEY_ADDR        6'h10
`define KEY_DATA        6'h11
`define KEY_REG         6'h12
`define KEY_PLUS        6'h13
`define KEY_MINUS       6'h14
`define KEY_RECALL      6'h15
`define KEY_GO          6'h16
`define KEY_STEP        6'h17
`define KEY_SUPERVISOR  6'h18
`define KEY_RESET       6'h19
`define KEY_INTERRUPT_REQUEST_KEY        6'h1A
`define KEY_USER        6'h1B
`define KEY_SBR         6'h1C
`define KEY_CBR         6'h1D
`define KEY_INS         6'h1E
`define KEY_DEL         6'h1F
`define KEY_MOVE        6'h20
`define KEY_RELA        6'h21
`define KEY_TAPE_WR     6'h22
`define KEY_TAPE_RD     6'h23
`define KEY_COUNT       36

// memory map
`define ROM_TOP         16'h0FFF
`define RAM_BASE        16'h1800
`define RAM_TOP         16'h1FFF
`define WORK_BASE       16'h1F9F
`define WORK_TOP        16'h1FF3
`define EXP_BASE        16'h2000
`define EXP_TOP         16'h2FFF
// io map, low byte of the port address
`define IO_KEYPORT_BASE 8'h00
`define IO_KEYPORT_TOP  8'h03
`define IO_TIMER_BASE   8'h40
`define IO_TIMER_TOP    8'h43
`define IO_PARPORT_BASE 8'h80
`define IO_PARPORT_TOP  8'h83
`define USER_KEY_BIT    6

// cpu clock: crystal divided by two
`define CRYSTAL_KHZ     3580
`define CPU_DIVIDE      2
`define SYS_KHZ         50000
// cpu cycle as a phase accumulator step: 2^16 * cpu_khz / sys_khz
`define CPU_STEP        ((65536 * (`CRYSTAL_KHZ / `CPU_DIVIDE)) / `SYS_KHZ)

// display
`define DIGITS          6
`define ERR_BANNER      24'hE0EEE0

`endif

// ---- src/keypad_monitor.v ----
// keypad monitor control: key interpreter, display fields, memory/io decode
// assumes one decoded key code per press with a held level, and a cpu core
// that honours run/step/stop requests and reports errors and step done
//
// Contract
// - address entry keeps last four digits
// - short address entry pads upper zeros
// - data entry is one byte, two digits
// - illegal key blanks whole display
// - program error shows banner until reset, supervisor, address, register or recall key
// - recall after reset loads lowest ram
// - run starts cpu at address field
// - plus advances, minus moves back one
// - data key switches entry to data
// - after each step monitor saves state
// - supervisor key stops user program
// - interrupt key drives interrupt request
// - user key is port 00 bit 6
// - register mode hex key selects register
// - basic ram decoded 1800 to 1FFF
// - expansion memory decoded 2000 to 2FFF
// - workspace 1F9F to 1FF3 is reserved
// - keypad and display port at 00-03
// - timer at 40-43, parallel port 80-83
// - six digits: four address, two data
// - keypad has thirty six keys
// - cpu clock is crystal divided two
// - entry points mark the active field, except register name entry, which shows no points
// - rom write blanks display while held
`timescale 1ns/100ps
`include "keypad_monitor_defines.vh"

module keypad_monitor (
  input  wire        I_CLOCK,
  input  wire        I_RESET_N,
  input  wire        I_KEY_VALID,
  input  wire [5:0]  I_KEY_CODE,
  input  wire        I_KEY_HELD,
  input  wire [7:0]  I_MEM_RDATA,
  input  wire [15:0] I_REG_RDATA,
  input  wire        I_STEP_DONE,
  input  wire        I_PROG_ERROR,
  input  wire [15:0] I_CPU_ADDR,
  input  wire        I_CPU_MREQ,
  input  wire        I_CPU_IOREQ,
  output reg  [15:0] O_MEM_ADDR,
  output reg  [7:0]  O_WDATA,
  output reg         O_MEM_WE,
  output reg  [3:0]  O_REG_SEL,
  output reg         O_REG_WE,
  output reg         O_REG_HIGH,
  output reg         O_RUN,
  output reg  [15:0] O_RUN_ADDR,
  output reg         O_STEP,
  output reg         O_STOP,
  output reg         O_SAVE_STATE,
  output reg         O_INT_REQ,
  output reg         O_USER_BIT,
  output reg         O_CPU_CLK,
  output reg         O_SEL_ROM,
  output reg         O_SEL_RAM,
  output reg         O_SEL_EXP,
  output reg         O_WORK_HIT,
  output reg         O_SEL_KEYPORT,
  output reg         O_SEL_TIMER,
  output reg         O_SEL_PARPORT,
  output reg  [23:0] O_DIGITS,
  output reg  [5:0]  O_POINTS,
  output reg         O_BLANK
);

  // *************************************************************
  // states
  // *************************************************************
  localparam [2:0] ST_IDLE     = 3'd0;
  localparam [2:0] ST_ADDR     = 3'd1;
  localparam [2:0] ST_DATA     = 3'd2;
  localparam [2:0] ST_REG_NAME = 3'd3;
  localparam [2:0] ST_REG_DATA = 3'd4;
  localparam [2:0] ST_RUNNING  = 3'd5;
  localparam [2:0] ST_STEPPING = 3'd6;
  localparam [2:0] ST_ERROR    = 3'd7;
  // accumulator step per system clock, cut to the accumulator width below
  localparam [31:0] PHASE_STEP = `CPU_STEP;

  reg  [2:0]  state;
  reg  [15:0] address;
  reg  [7:0]  data_byte;
  reg  [3:0]  reg_sel;
  reg         reg_high;
  reg         after_reset;
  reg         err_blank;
  reg         rom_blank;
  reg  [15:0] phase;
  reg         entry_fresh;
  wire [16:0] phase_sum;
  wire        is_hex;
  wire [3:0]  nibble;
  wire        addr_rom;

  function in_range;
    input [15:0] value;
    input [15:0] low;
    input [15:0] high;
    begin
      in_range = (value >= low) && (value <= high);
    end
  endfunction

  function [7:0] shift_byte;
    input [7:0] old;
    input [3:0] digit;
    input       fresh;
    begin
      // a fresh entry starts from zero, so one digit reads as 0d
      shift_byte = {fresh ? 4'h0 : old[3:0], digit};
    end
  endfunction

  // codes below 10 are hex keys
  assign is_hex    = I_KEY_VALID && (I_KEY_CODE < 6'h10);
  assign nibble    = I_KEY_CODE[3:0];
  assign addr_rom  = in_range(address, 16'h0000, `ROM_TOP);
  assign phase_sum = {1'b0, phase} + {1'b0, PHASE_STEP[15:0]};

  // *************************************************************
  // cpu clock
  // *************************************************************
  // crystal halved clock
  // average rate runs slightly low from the truncated step; each edge jitters by one system clock
  always @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      phase     <= 16'h0000;
      O_CPU_CLK <= 1'b0;
    end else begin
      phase     <= phase_sum[15:0];
      O_CPU_CLK <= phase[15];
    end
  end

  // *************************************************************
  // address decode
  // *************************************************************
  always @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      O_SEL_ROM     <= 1'b0;
      O_SEL_RAM     <= 1'b0;
      O_SEL_EXP     <= 1'b0;
      O_WORK_HIT    <= 1'b0;
      O_SEL_KEYPORT <= 1'b0;
      O_SEL_TIMER   <= 1'b0;
      O_SEL_PARPORT <= 1'b0;
      O_USER_BIT    <= 1'b0;
    end else begin
      O_SEL_ROM     <= I_CPU_MREQ && in_range(I_CPU_ADDR, 16'h0000, `ROM_TOP);
      O_SEL_RAM     <= I_CPU_MREQ && in_range(I_CPU_ADDR, `RAM_BASE, `RAM_TOP);
      O_SEL_EXP     <= I_CPU_MREQ && in_range(I_CPU_ADDR, `EXP_BASE, `EXP_TOP);
      O_WORK_HIT    <= I_CPU_MREQ && in_range(I_CPU_ADDR, `WORK_BASE, `WORK_TOP);
      O_SEL_KEYPORT <= I_CPU_IOREQ &&
                       in_range({8'h00, I_CPU_ADDR[7:0]}, {8'h00, `IO_KEYPORT_BASE},
                                {8'h00, `IO_KEYPORT_TOP});
      O_SEL_TIMER   <= I_CPU_IOREQ &&
                       in_range({8'h00, I_CPU_ADDR[7:0]}, {8'h00, `IO_TIMER_BASE},
                                {8'h00, `IO_TIMER_TOP});
      O_SEL_PARPORT <= I_CPU_IOREQ &&
                       in_range({8'h00, I_CPU_ADDR[7:0]}, {8'h00, `IO_PARPORT_BASE},
                                {8'h00, `IO_PARPORT_TOP});
      O_USER_BIT    <= I_KEY_HELD && (I_KEY_CODE == `KEY_USER);
    end
  end

  // *************************************************************
  // key interpreter
  // *************************************************************
  always @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      state        <= ST_IDLE;
      address      <= 16'h0000;
      data_byte    <= 8'h00;
      reg_sel      <= 4'h0;
      reg_high     <= 1'b1;
      after_reset  <= 1'b1;
      entry_fresh  <= 1'b1;
      err_blank    <= 1'b0;
      rom_blank    <= 1'b0;
      O_MEM_WE     <= 1'b0;
      O_REG_WE     <= 1'b0;
      O_WDATA      <= 8'h00;
      O_RUN        <= 1'b0;
      O_RUN_ADDR   <= 16'h0000;
      O_STEP       <= 1'b0;
      O_STOP       <= 1'b0;
      O_SAVE_STATE <= 1'b0;
      O_INT_REQ    <= 1'b0;
    end else begin
      O_MEM_WE     <= 1'b0;
      O_REG_WE     <= 1'b0;
      O_RUN        <= 1'b0;
      O_STEP       <= 1'b0;
      O_STOP       <= 1'b0;
      O_SAVE_STATE <= 1'b0;
      O_INT_REQ    <= I_KEY_HELD && (I_KEY_CODE == `KEY_INTERRUPT_REQUEST_KEY);
      // blank held only while key down
      if (rom_blank && !I_KEY_HELD)
        rom_blank <= 1'b0;
      if (state == ST_STEPPING && I_STEP_DONE) begin
        O_SAVE_STATE <= 1'b1;
        state        <= ST_ADDR;
      end
      if ((state == ST_RUNNING || state == ST_STEPPING) && I_PROG_ERROR)
        state <= ST_ERROR;
      if (I_KEY_VALID) begin
        err_blank <= 1'b0;
        entry_fresh <= !is_hex;
        if (I_KEY_CODE == `KEY_RESET) begin
          state       <= ST_IDLE;
          after_reset <= 1'b1;
        end else if (I_KEY_CODE == `KEY_SUPERVISOR) begin
          if (state == ST_RUNNING || state == ST_STEPPING)
            O_STOP <= 1'b1;
          state <= ST_ADDR;
        end else if (I_KEY_CODE == `KEY_INTERRUPT_REQUEST_KEY || I_KEY_CODE == `KEY_USER) begin
          state <= state;
        // a running program only hears the reset, stop and pin keys
        end else if (state == ST_RUNNING) begin
          state <= state;
        end else if (I_KEY_CODE == `KEY_ADDR) begin
          state <= ST_ADDR;
        end else if (I_KEY_CODE == `KEY_REG) begin
          state <= ST_REG_NAME;
        end else if (I_KEY_CODE == `KEY_RECALL) begin
          if (after_reset)
            address <= `RAM_BASE;
          after_reset <= 1'b0;
          state       <= ST_ADDR;
        end else if (I_KEY_CODE == `KEY_GO &&
                     (state == ST_ADDR || state == ST_DATA)) begin
          O_RUN      <= 1'b1;
          O_RUN_ADDR <= address;
          state      <= ST_RUNNING;
        end else if (I_KEY_CODE == `KEY_STEP &&
                     (state == ST_ADDR || state == ST_DATA)) begin
          O_STEP     <= 1'b1;
          O_RUN_ADDR <= address;
          state      <= ST_STEPPING;
        end else if (I_KEY_CODE == `KEY_DATA && (state == ST_ADDR || state == ST_DATA)) begin
          data_byte <= I_MEM_RDATA;
          state     <= ST_DATA;
        // data, plus or minus open the selected register's bytes
        end else if (I_KEY_CODE == `KEY_DATA &&
                     (state == ST_REG_NAME || state == ST_REG_DATA)) begin
          state <= ST_REG_DATA;
        end else if ((I_KEY_CODE == `KEY_PLUS || I_KEY_CODE == `KEY_MINUS) &&
                     (state == ST_ADDR || state == ST_DATA)) begin
          address <= (I_KEY_CODE == `KEY_PLUS) ? address + 16'h0001
                                               : address - 16'h0001;
          state   <= ST_DATA;
        end else if ((I_KEY_CODE == `KEY_PLUS || I_KEY_CODE == `KEY_MINUS) &&
                     (state == ST_REG_NAME || state == ST_REG_DATA)) begin
          if (reg_high != (I_KEY_CODE == `KEY_PLUS))
            reg_sel <= (I_KEY_CODE == `KEY_PLUS) ? reg_sel + 4'h1 : reg_sel - 4'h1;
          reg_high <= !reg_high;
          state    <= ST_REG_DATA;
        end else if (is_hex && state == ST_ADDR) begin
          // first digit of an entry drops the old digits
          address <= {entry_fresh ? 12'h000 : address[11:0], nibble};
        end else if (is_hex && state == ST_DATA) begin
          if (addr_rom) begin
            rom_blank <= 1'b1;
          end else begin
            data_byte <= shift_byte(data_byte, nibble, entry_fresh);
            O_WDATA   <= shift_byte(data_byte, nibble, entry_fresh);
            O_MEM_WE  <= 1'b1;
          end
        end else if (is_hex && state == ST_REG_NAME) begin
          reg_sel  <= nibble;
          reg_high <= 1'b1;
          state    <= ST_REG_NAME;
        end else if (is_hex && state == ST_REG_DATA) begin
          data_byte <= shift_byte(data_byte, nibble, entry_fresh);
          O_WDATA   <= shift_byte(data_byte, nibble, entry_fresh);
          O_REG_WE  <= 1'b1;
        end else begin
          err_blank <= 1'b1;
        end
      end
    end
  end

  // *************************************************************
  // display
  // *************************************************************
  always @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      O_MEM_ADDR <= 16'h0000;
      O_REG_SEL  <= 4'h0;
      O_REG_HIGH <= 1'b1;
      O_DIGITS   <= 24'h000000;
      O_POINTS   <= 6'h00;
      O_BLANK    <= 1'b0;
    end else begin
      O_MEM_ADDR <= address;
      O_REG_SEL  <= reg_sel;
      O_REG_HIGH <= reg_high;
      O_BLANK    <= err_blank || rom_blank;
      // four address and two data digits
      if (state == ST_ERROR)
        O_DIGITS <= `ERR_BANNER;
      // register mode: contents left, name code right
      else if (state == ST_REG_DATA || state == ST_REG_NAME)
        O_DIGITS <= {I_REG_RDATA, 4'h0, reg_sel};
      else
        O_DIGITS <= {address, (state == ST_DATA) ? I_MEM_RDATA : data_byte};
      if (state == ST_ADDR)
        O_POINTS <= 6'h3C;
      else if (state == ST_DATA)
        O_POINTS <= 6'h03;
      else if (state == ST_REG_DATA)
        O_POINTS <= reg_high ? 6'h30 : 6'h0C;
      else
        O_POINTS <= 6'h00;
    end
  end

endmodule // keypad_monitor

// ---- verification/keypad_monitor_props.sv ----
// port assertions for the keypad monitor, bound into every instance
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
`include "keypad_monitor_defines.vh"
module keypad_monitor_props (
  input wire        I_CLOCK,
  input wire        I_RESET_N,
  input wire        I_KEY_VALID,
  input wire [5:0]  I_KEY_CODE,
  input wire        I_KEY_HELD,
  input wire        I_STEP_DONE,
  input wire [15:0] I_CPU_ADDR,
  input wire        I_CPU_MREQ,
  input wire [15:0] O_MEM_ADDR,
  input wire [7:0]  O_WDATA,
  input wire        O_MEM_WE,
  input wire        O_RUN,
  input wire [15:0] O_RUN_ADDR,
  input wire        O_SAVE_STATE,
  input wire        O_INT_REQ,
  input wire        O_USER_BIT,
  input wire        O_CPU_CLK,
  input wire        O_SEL_RAM
);
  // ********
  // cpu clock rise spacing
  // ********
  reg       clk_q;
  reg [5:0] gap;
  reg       seen;
  wire      rise = O_CPU_CLK & ~clk_q;
  always @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      clk_q <= 1'b0;
      gap   <= 6'h00;
      seen  <= 1'b0;
    end else begin
      clk_q <= O_CPU_CLK;
      gap   <= rise ? 6'h00 : gap + 6'h01;
      seen  <= seen | rise;
    end
  end
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);
  property p_run_start;
    O_RUN |-> $past(I_KEY_VALID && I_KEY_CODE == `KEY_GO) && O_RUN_ADDR == O_MEM_ADDR;
  endproperty
  a_run_start: assert property (p_run_start) else $error("run start wrong");
  property p_save;
    I_STEP_DONE |=> O_SAVE_STATE;
  endproperty
  a_save: assert property (p_save) else $error("no state save after step");
  property p_int_level;
    $past(I_RESET_N) |-> O_INT_REQ == $past(I_KEY_HELD && I_KEY_CODE == `KEY_INTERRUPT_REQUEST_KEY);
  endproperty
  a_int_level: assert property (p_int_level) else $error("interrupt level wrong");
  property p_user_level;
    $past(I_RESET_N) |-> O_USER_BIT == $past(I_KEY_HELD && I_KEY_CODE == `KEY_USER);
  endproperty
  a_user_level: assert property (p_user_level) else $error("user bit wrong");
  // 1800-1FFF is exactly the top five address bits 00011
  property p_ram_decode;
    $past(I_RESET_N && I_CPU_MREQ) |-> O_SEL_RAM == ($past(I_CPU_ADDR[15:11]) == 5'h03);
  endproperty
  a_ram_decode: assert property (p_ram_decode) else $error("ram decode wrong");
  property p_rom_guard;
    O_MEM_WE |-> O_MEM_ADDR > `ROM_TOP && $past(I_KEY_VALID && I_KEY_CODE < 6'h10);
  endproperty
  a_rom_guard: assert property (p_rom_guard) else $error("bad memory write");
  property p_write_byte;
    O_MEM_WE |-> O_WDATA[3:0] == $past(I_KEY_CODE[3:0]);
  endproperty
  a_write_byte: assert property (p_write_byte) else $error("write byte wrong");
  property p_cpu_clk;
    rise && seen |-> gap >= 6'h1A && gap <= 6'h1B;
  endproperty
  a_cpu_clk: assert property (p_cpu_clk) else $error("cpu clock period wrong");
  c_run: cover property (O_RUN);
  c_write: cover property (O_MEM_WE);
  c_save: cover property (I_STEP_DONE ##1 O_SAVE_STATE);
endmodule // keypad_monitor_props
bind keypad_monitor keypad_monitor_props u_keypad_monitor_props (
  .I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N), .I_KEY_VALID(I_KEY_VALID),
  .I_KEY_CODE(I_KEY_CODE), .I_KEY_HELD(I_KEY_HELD), .I_STEP_DONE(I_STEP_DONE),
  .I_CPU_ADDR(I_CPU_ADDR), .I_CPU_MREQ(I_CPU_MREQ), .O_MEM_ADDR(O_MEM_ADDR),
  .O_WDATA(O_WDATA), .O_MEM_WE(O_MEM_WE), .O_RUN(O_RUN), .O_RUN_ADDR(O_RUN_ADDR),
  .O_SAVE_STATE(O_SAVE_STATE), .O_INT_REQ(O_INT_REQ), .O_USER_BIT(O_USER_BIT),
  .O_CPU_CLK(O_CPU_CLK), .O_SEL_RAM(O_SEL_RAM));

// ---- verification/keyer.sv ----
// keypad operator model: presses one key at a time
// assumes keys are sampled on the rising clock edge
`timescale 1ns/100ps
module keyer (
  input  wire       i_clock,
  output reg        o_key_valid,
  output reg  [5:0] o_key_code,
  output reg        o_key_held
);
  initial begin
    o_key_valid = 1'b0;
    o_key_code  = 6'h3F;
    o_key_held  = 1'b0;
  end
  // one-cycle strobe; the key stays down for hold cycles in all, strobe cycle included
  task press(input [5:0] code, input integer hold);
    integer n;
    begin
      @(posedge i_clock);
      #1;
      o_key_valid = 1'b1;
      o_key_code  = code;
      o_key_held  = 1'b1;
      for (n = 0; n < hold; n = n + 1) begin
        @(posedge i_clock);
        #1;
        o_key_valid = 1'b0;
      end
      // released: code lines no longer show the old key
      o_key_held = 1'b0;
      o_key_code = ~code;
    end
  endtask
endmodule // keyer

// ---- verification/tb_top.sv ----
// self-checking bench for the keypad monitor
// assumes the keyer model drives keys; the bench plays the cpu side
`timescale 1ns/100ps
`include "keypad_monitor_defines.vh"
module tb_top;
  reg         clk;
  reg         rst_n;
  reg  [15:0] cpu_addr;
  reg         mreq;
  reg         step_done;
  reg         prog_err;
  wire        key_valid;
  wire [5:0]  key_code;
  wire        key_held;
  wire [15:0] mem_addr;
  wire [7:0]  wdata;
  wire        mem_we;
  wire [3:0]  reg_sel;
  wire        run;
  wire [15:0] run_addr;
  wire        step;
  wire        stop;
  wire        save;
  wire        int_req;
  wire        user_bit;
  wire [5:0]  sel;
  wire [23:0] digits;
  wire [5:0]  points;
  wire        blank;
  wire        reg_we;
  wire        reg_hi;
  wire        sel_rom;
  integer     bad_count, num_checks, n_we, n_run, n_step, n_stop, n_save, n_rwe;
  reg  [15:0] got_addr;
  reg  [7:0]  got_data;
  keyer u_keyer (.i_clock(clk), .o_key_valid(key_valid), .o_key_code(key_code),
    .o_key_held(key_held));
  keypad_monitor u_keypad_monitor (
    .I_CLOCK(clk), .I_RESET_N(rst_n), .I_KEY_VALID(key_valid), .I_KEY_CODE(key_code),
    .I_KEY_HELD(key_held), .I_MEM_RDATA(8'h5A), .I_REG_RDATA(16'h1234),
    .I_STEP_DONE(step_done), .I_PROG_ERROR(prog_err), .I_CPU_ADDR(cpu_addr),
    .I_CPU_MREQ(mreq), .I_CPU_IOREQ(!mreq), .O_MEM_ADDR(mem_addr), .O_WDATA(wdata),
    .O_MEM_WE(mem_we), .O_REG_SEL(reg_sel), .O_REG_WE(reg_we), .O_REG_HIGH(reg_hi),
    .O_RUN(run),
    .O_RUN_ADDR(run_addr), .O_STEP(step), .O_STOP(stop), .O_SAVE_STATE(save),
    .O_INT_REQ(int_req), .O_USER_BIT(user_bit), .O_CPU_CLK(), .O_SEL_ROM(sel_rom),
    .O_SEL_RAM(sel[5]), .O_SEL_EXP(sel[4]), .O_WORK_HIT(sel[3]), .O_SEL_KEYPORT(sel[2]),
    .O_SEL_TIMER(sel[1]), .O_SEL_PARPORT(sel[0]), .O_DIGITS(digits), .O_POINTS(points),
    .O_BLANK(blank));
  // ********
  // strobe capture and helpers
  // ********
  always @(posedge clk) begin
    if (mem_we === 1'b1) begin
      n_we = n_we + 1;
      got_addr = mem_addr;
      got_data = wdata;
    end
    if (run === 1'b1) begin
      n_run = n_run + 1;
      got_addr = run_addr;
    end
    if (reg_we === 1'b1) begin
      n_rwe = n_rwe + 1;
      got_data = wdata;
    end
    n_step = n_step + (step === 1'b1);
    n_stop = n_stop + (stop === 1'b1);
    n_save = n_save + (save === 1'b1);
  end
  task check(input ok, input string what);
    begin
      num_checks = num_checks + 1;
      if (!ok) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0t %s", $time, what);
      end
    end
  endtask
  task k(input [5:0] c);
    u_keyer.press(c, 3);
  endtask
  task results;
    begin
      if (bad_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task dec(input [15:0] a, input m, input [5:0] e);
    begin
      @(posedge clk);
      #1 cpu_addr = a;
      mreq = m;
      repeat (2) @(posedge clk);
      #1 check(sel === e, "decode");
    end
  endtask
  task pulse_step;
    begin
      @(posedge clk);
      #1 step_done = 1'b1;
      @(posedge clk);
      #1 step_done = 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  // ********
  // scenarios
  // ********
  task t_run;
    begin
      k(`KEY_ADDR);
      k(6'h01);
      k(6'h08);
      check(mem_addr === 16'h0018, "short address");
      check(points === 6'h3C, "address points");
      k(`KEY_RECALL);
      check(mem_addr === `RAM_BASE, "recall");
      check(digits[23:8] === 16'h1800, "recall digits");
      k(`KEY_GO);
      check(n_run == 1 && got_addr === 16'h1800, "run");
      k(`KEY_SUPERVISOR);
      check(n_stop == 1, "stop");
    end
  endtask
  task t_data;
    begin
      k(`KEY_ADDR);
      k(6'h02);
      k(6'h01);
      k(6'h08);
      k(6'h04);
      k(6'h00);
      check(mem_addr === 16'h1840, "long address");
      k(`KEY_DATA);
      check(points === 6'h03, "data points");
      k(6'h03);
      check(n_we == 1 && got_data === 8'h03, "single digit");
      k(6'h0A);
      k(6'h0B);
      check(n_we == 3 && got_addr === 16'h1840 && got_data === 8'hAB, "byte");
      check(digits === 24'h18405A, "data display");
      k(`KEY_PLUS);
      check(mem_addr === 16'h1841, "plus");
      k(`KEY_MINUS);
      k(`KEY_MINUS);
      check(mem_addr === 16'h183F, "minus");
      k(`KEY_ADDR);
      k(6'h07);
      check(mem_addr === 16'h0007, "fresh address");
    end
  endtask
  task t_rom;
    begin
      k(`KEY_ADDR);
      repeat (4) k(6'h00);
      k(`KEY_DATA);
      n_we = 0;
      fork
        u_keyer.press(6'h05, 6);
        begin
          repeat (4) @(posedge clk);
          #2 check(blank === 1'b1, "rom blank");
        end
      join
      repeat (3) @(posedge clk);
      #1 check(blank === 1'b0 && n_we == 0, "rom restore");
    end
  endtask
  task t_reg;
    integer r;
    begin
      k(`KEY_REG);
      for (r = 0; r < 16; r = r + 1) begin
        k(r[5:0]);
        check(reg_sel === r[3:0], "register select");
      end
      check(digits === 24'h12340F, "register display");
      k(`KEY_DATA);
      check(points === 6'h30, "register points");
      k(6'h01);
      k(6'h02);
      check(n_rwe == 2 && got_data === 8'h12, "register byte");
      k(`KEY_PLUS);
      check(reg_hi === 1'b0 && reg_sel === 4'hF, "register plus");
      n_run = 0;
      k(`KEY_GO);
      check(blank === 1'b1 && n_run == 0, "illegal key");
      k(6'h24);
      check(blank === 1'b1, "not a key");
      k(`KEY_ADDR);
      check(blank === 1'b0, "blank cleared");
    end
  endtask
  task t_step;
    begin
      k(`KEY_STEP);
      check(n_step == 1, "step");
      pulse_step;
      #1 check(n_save == 1, "save state");
    end
  endtask
  task t_err;
    integer i;
    begin
      // program errors only arise while the user program runs or steps
      k(`KEY_GO);
      @(posedge clk);
      #1 prog_err = 1'b1;
      @(posedge clk);
      #1 prog_err = 1'b0;
      for (i = 0; i < 8 && digits !== `ERR_BANNER; i = i + 1) @(posedge clk);
      #1 check(digits === `ERR_BANNER, "error banner");
      if (i == 8) results;
      k(`KEY_ADDR);
      check(digits !== `ERR_BANNER, "banner cleared");
    end
  endtask
  task t_hold(input [5:0] c);
    begin
      fork
        u_keyer.press(c, 4);
        begin
          repeat (3) @(posedge clk);
          #2 check({int_req, user_bit} === {c == `KEY_INTERRUPT_REQUEST_KEY, c == `KEY_USER}, "held");
        end
      join
      repeat (2) @(posedge clk);
      #1 check({int_req, user_bit} === 2'b00, "released");
    end
  endtask
  task t_decode;
    begin
      dec(16'h17FF, 1'b1, 6'b000000);
      dec(16'h1F9F, 1'b1, 6'b101000);
      dec(16'h1FF3, 1'b1, 6'b101000);
      dec(16'h1FF4, 1'b1, 6'b100000);
      dec(16'h2FFF, 1'b1, 6'b010000);
      dec(16'h0003, 1'b0, 6'b000100);
      dec(16'h0043, 1'b0, 6'b000010);
      dec(16'h0080, 1'b0, 6'b000001);
      dec(16'h0044, 1'b0, 6'b000000);
      dec(16'h1800, 1'b1, 6'b100000);
      dec(16'h2000, 1'b1, 6'b010000);
      dec(16'h0FFF, 1'b1, 6'b000000);
      check(sel_rom === 1'b1, "rom decode");
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    cpu_addr = 16'h0000;
    mreq = 1'b0;
    step_done = 1'b0;
    prog_err = 1'b0;
    {bad_count, num_checks, n_we, n_run, n_step, n_stop, n_save, n_rwe} = 0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    t_run;
    t_data;
    t_rom;
    t_reg;
    t_step;
    t_err;
    t_hold(`KEY_INTERRUPT_REQUEST_KEY);
    t_hold(`KEY_USER);
    t_decode;
    results;
  end
endmodule // tb_top
